// [inc/uefc_cfg.svh]
// Offsets, field positions and reset values of the extended-feature register block
// What this block does
// - Write-only select register; bank field picks general, first extra or second extra set
// - Select bit 0 set makes the transmit and receive level counters readable
// - Bank field wins over bit 0; counters readable only with bank zero
// - Eight-bit scratch register returns what was written, affects nothing else
// - Baud divisor is sixteen bits from high and low byte latches
// - Transmit space counter is read-only and shows free transmit FIFO entries
// - Receive fill counter is read-only and shows characters held in receive FIFO
// - Enhanced bit 7 halts transmission while CTS is one
// - Enhanced bit 6: interrupt at trigger, RTS high above it, low below next lower
// - Without automatic flow control RTS follows the software modem control bit
// - Enhanced bit 5 compares received characters with second pause character, sets status bit 4
// - Bit 0 of flow-control characters compares with received character's least significant bit
// - Enhanced interrupt, FIFO and modem control bits change only while enhanced bit 4 is set; software RTS bit 16 is always written
// - Enhanced bit 4 set enables enhanced features and restores the kept settings
// - Flow-control select bits reset to zero; upper two choose transmit characters
// - Dual-character mode treats both characters as one consecutive sequence
// - Lower two select bits choose receive comparison: first pair, second pair, or both
// - Select register shares its address with modem status; reads return modem status
`ifndef UEFC_CFG_SVH
`define UEFC_CFG_SVH
`define UEFC_OFS_SELECT   8'h00
`define UEFC_OFS_SCRATCH  8'h04
`define UEFC_OFS_DIV_LOW  8'h08
`define UEFC_OFS_DIV_HIGH 8'h0C
`define UEFC_OFS_TX_SPACE 8'h10
`define UEFC_OFS_RX_FILL  8'h14
`define UEFC_OFS_ENH_CTRL 8'h18
`define UEFC_OFS_ENH_BITS 8'h1C
`define UEFC_OFS_CHARS    8'h20
`define UEFC_OFS_STATUS   8'h24
`define UEFC_OFS_TRIGGER  8'h28
`define UEFC_SEL_CNT_BIT  0
`define UEFC_EFR_CTS_BIT  7
`define UEFC_EFR_RTS_BIT  6
`define UEFC_EFR_SPC_BIT  5
`define UEFC_EFR_ENH_BIT  4
`define UEFC_STS_SPC_BIT  4
`define UEFC_STS_TRG_BIT  0
`define UEFC_ENH_SW_RTS   16
`define UEFC_RST_BYTE     8'h00
`define UEFC_RST_TRIGGER  8'h01
`endif

// [inc/uefc_pkg.sv]
// Types shared by the extended-feature register block
package uefc_pkg;
    typedef enum logic [1:0] {
        UEFC_BANK_GENERAL = 2'b00,
        UEFC_BANK_EXTRA1  = 2'b01,
        UEFC_BANK_EXTRA2  = 2'b10,
        UEFC_BANK_RSVD    = 2'b11
    } uefc_bank_t;
    typedef enum logic [1:0] {
        UEFC_SEQ_IDLE   = 2'b00,
        UEFC_SEQ_RES1   = 2'b01,
        UEFC_SEQ_PAUSE1 = 2'b10
    } uefc_seq_t;
    typedef struct packed {
        logic       write;
        logic [7:0] addr;
    } uefc_req_t;
endpackage

// [design/uefc_top.sv]
// Extended-feature register logic of one UART channel with an AHB-Lite slave
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "uefc_cfg.svh"
module uefc_top (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    input  wire logic        cts_in,
    input  wire logic [7:0]  modem_status_in,
    input  wire logic [7:0]  tx_free_in,
    input  wire logic [7:0]  rx_fill_in,
    input  wire logic        rx_char_valid_in,
    input  wire logic [7:0]  rx_char_in,
    output logic      [15:0] divisor_out,
    output logic      [8:0]  enh_bits_out,
    output logic             tx_halt_out,
    output logic             rts_out,
    output logic             rx_trig_irq_out,
    output logic      [1:0]  sw_tx_mode_out,
    output logic             rx_resume_out,
    output logic             rx_pause_out
);
    uefc_pkg::uefc_req_t  req_q;
    uefc_pkg::uefc_bank_t bank_q;
    uefc_pkg::uefc_seq_t  seq_q, seq_d;
    logic        wr_pend_q, rd_pend_q, ready_q;
    logic        cnt_en_q, cts_m_q, cts_q, rts_auto_q, sw_rts_q, spc_q, trg_q;
    logic [31:0] rdata_q;
    logic [7:0]  scratch_q, div_lo_q, div_hi_q, efr_q, trig_q;
    logic [7:0]  res1_q, res2_q, pause1_q, pause2_q;
    logic [8:0]  enh_q;
    logic        resume_q, pause_q;

    // Bank visibility decode, used for both reads and writes
    function automatic logic visible(input logic [7:0] a, input uefc_pkg::uefc_bank_t b);
        if (a == `UEFC_OFS_SELECT || a == `UEFC_OFS_STATUS) visible = 1'b1;
        else if (a == `UEFC_OFS_SCRATCH || a == `UEFC_OFS_TX_SPACE || a == `UEFC_OFS_RX_FILL
                 || a == `UEFC_OFS_ENH_BITS)
            visible = (b == uefc_pkg::UEFC_BANK_GENERAL);
        else if (a == `UEFC_OFS_DIV_LOW || a == `UEFC_OFS_DIV_HIGH || a == `UEFC_OFS_TRIGGER)
            visible = (b == uefc_pkg::UEFC_BANK_EXTRA1);
        else if (a == `UEFC_OFS_ENH_CTRL || a == `UEFC_OFS_CHARS)
            visible = (b == uefc_pkg::UEFC_BANK_EXTRA2);
        else visible = 1'b0;
    endfunction

    wire       accept   = hsel_in & htrans_in[1] & ready_q;
    wire       wr_vis   = wr_pend_q & visible(req_q.addr, bank_q);
    wire       rd_vis   = rd_pend_q & visible(req_q.addr, bank_q);
    wire       wr_sel   = wr_vis && req_q.addr == `UEFC_OFS_SELECT;
    wire       wr_scr   = wr_vis && req_q.addr == `UEFC_OFS_SCRATCH;
    wire       wr_dlo   = wr_vis && req_q.addr == `UEFC_OFS_DIV_LOW;
    wire       wr_dhi   = wr_vis && req_q.addr == `UEFC_OFS_DIV_HIGH;
    wire       wr_efr   = wr_vis && req_q.addr == `UEFC_OFS_ENH_CTRL;
    wire       wr_enh   = wr_vis && req_q.addr == `UEFC_OFS_ENH_BITS;
    wire       wr_chr   = wr_vis && req_q.addr == `UEFC_OFS_CHARS;
    wire       wr_trg   = wr_vis && req_q.addr == `UEFC_OFS_TRIGGER;
    wire       rd_sts   = rd_vis && req_q.addr == `UEFC_OFS_STATUS;
    wire       cnt_ok   = cnt_en_q && bank_q == uefc_pkg::UEFC_BANK_GENERAL;
    wire [1:0] new_bank = hwdata_in[2:1];
    wire [1:0] rx_mode  = efr_q[1:0];
    wire [1:0] tx_mode  = efr_q[3:2];
    wire       dual     = rx_mode == 2'b11 && tx_mode == 2'b11;
    // Full byte compare, so bit 0 of each character meets the received LSB
    wire       m_res1   = rx_char_in == res1_q;
    wire       m_res2   = rx_char_in == res2_q;
    wire       m_pau1   = rx_char_in == pause1_q;
    wire       m_pau2   = rx_char_in == pause2_q;
    wire       single   = rx_mode == 2'b11 && !dual;
    wire       hit_res  = rx_char_valid_in && !dual && ((rx_mode == 2'b10 && m_res1) ||
                          (rx_mode == 2'b01 && m_res2) || (single && (m_res1 || m_res2)));
    wire       hit_pau  = rx_char_valid_in && !dual && ((rx_mode == 2'b10 && m_pau1) ||
                          (rx_mode == 2'b01 && m_pau2) || (single && (m_pau1 || m_pau2)));
    wire       seq_res  = rx_char_valid_in && dual && seq_q == uefc_pkg::UEFC_SEQ_RES1 && m_res2;
    wire       seq_pau  = rx_char_valid_in && dual && seq_q == uefc_pkg::UEFC_SEQ_PAUSE1 && m_pau2;
    wire       spc_hit  = rx_char_valid_in && efr_q[`UEFC_EFR_SPC_BIT] && m_pau2;
    wire [8:0] fill9    = {1'b0, rx_fill_in};
    wire [8:0] trig9    = {1'b0, trig_q};
    wire       at_trig  = fill9 >= trig9;
    wire       rts_set  = fill9 >= trig9 + 9'h001;
    wire       rts_clr  = fill9 + 9'h001 < trig9;

    wire [31:0] rd_word =
        !rd_vis                             ? 32'h0000_0000 :
        req_q.addr == `UEFC_OFS_SELECT      ? {24'h000000, modem_status_in} :
        req_q.addr == `UEFC_OFS_SCRATCH     ? {24'h000000, scratch_q} :
        req_q.addr == `UEFC_OFS_DIV_LOW     ? {24'h000000, div_lo_q} :
        req_q.addr == `UEFC_OFS_DIV_HIGH    ? {24'h000000, div_hi_q} :
        req_q.addr == `UEFC_OFS_TX_SPACE    ? {24'h000000, cnt_ok ? tx_free_in : 8'h00} :
        req_q.addr == `UEFC_OFS_RX_FILL     ? {24'h000000, cnt_ok ? rx_fill_in : 8'h00} :
        req_q.addr == `UEFC_OFS_ENH_CTRL    ? {24'h000000, efr_q} :
        req_q.addr == `UEFC_OFS_ENH_BITS    ? {15'h0000, sw_rts_q, 5'h00, enh_q[8:6], 2'h0, enh_q[5:0]} :
        req_q.addr == `UEFC_OFS_CHARS       ? {pause2_q, pause1_q, res2_q, res1_q} :
        req_q.addr == `UEFC_OFS_STATUS      ? {27'h0000000, spc_q, 3'h0, trg_q} :
        req_q.addr == `UEFC_OFS_TRIGGER     ? {24'h000000, trig_q} : 32'h0000_0000;

    always_comb begin
        seq_d = seq_q;
        if (rx_char_valid_in && dual) begin
            if (m_res1) seq_d = uefc_pkg::UEFC_SEQ_RES1;
            else if (m_pau1) seq_d = uefc_pkg::UEFC_SEQ_PAUSE1;
            else seq_d = uefc_pkg::UEFC_SEQ_IDLE;
        end else if (!dual) begin
            seq_d = uefc_pkg::UEFC_SEQ_IDLE;
        end
    end

    // Bus phase tracking; reads take one wait state so a write just before lands first
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            req_q     <= '0;
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            ready_q   <= 1'b1;
            rdata_q   <= 32'h0000_0000;
        end else begin
            wr_pend_q <= accept & hwrite_in;
            rd_pend_q <= accept & ~hwrite_in;
            ready_q   <= ~(accept & ~hwrite_in);
            if (accept) req_q <= '{write: hwrite_in, addr: {haddr_in[7:2], 2'b00}};
            if (rd_pend_q) rdata_q <= rd_word;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            bank_q   <= uefc_pkg::UEFC_BANK_GENERAL;
            cnt_en_q <= 1'b0;
        end else if (wr_sel) begin
            // The reserved bank code is dropped and the old bank kept
            if (new_bank != uefc_pkg::UEFC_BANK_RSVD) bank_q <= uefc_pkg::uefc_bank_t'(new_bank);
            cnt_en_q <= hwdata_in[`UEFC_SEL_CNT_BIT];
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            scratch_q <= `UEFC_RST_BYTE;
            div_lo_q  <= `UEFC_RST_BYTE;
            div_hi_q  <= `UEFC_RST_BYTE;
            trig_q    <= `UEFC_RST_TRIGGER;
        end else begin
            if (wr_scr) scratch_q <= hwdata_in[7:0];
            if (wr_dlo) div_lo_q <= hwdata_in[7:0];
            if (wr_dhi) div_hi_q <= hwdata_in[7:0];
            if (wr_trg) trig_q <= hwdata_in[7:0];
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            efr_q    <= `UEFC_RST_BYTE;
            res1_q   <= `UEFC_RST_BYTE;
            res2_q   <= `UEFC_RST_BYTE;
            pause1_q <= `UEFC_RST_BYTE;
            pause2_q <= `UEFC_RST_BYTE;
        end else begin
            if (wr_efr) efr_q <= hwdata_in[7:0];
            if (wr_chr) {pause2_q, pause1_q, res2_q, res1_q} <= hwdata_in;
        end
    end

    // Enhanced bits keep their value while the gate is shut and reappear when it opens
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            enh_q    <= 9'h000;
            sw_rts_q <= 1'b0;
        end else if (wr_enh) begin
            if (efr_q[`UEFC_EFR_ENH_BIT]) enh_q <= {hwdata_in[10:8], hwdata_in[5:0]};
            sw_rts_q <= hwdata_in[`UEFC_ENH_SW_RTS];
        end
    end

    // CTS pin is asynchronous to this clock
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cts_m_q <= 1'b0;
            cts_q   <= 1'b0;
        end else begin
            cts_m_q <= cts_in;
            cts_q   <= cts_m_q;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            rts_auto_q <= 1'b0;
            spc_q      <= 1'b0;
            trg_q      <= 1'b0;
            seq_q      <= uefc_pkg::UEFC_SEQ_IDLE;
            resume_q   <= 1'b0;
            pause_q    <= 1'b0;
        end else begin
            if (rts_set) rts_auto_q <= 1'b1;
            else if (rts_clr) rts_auto_q <= 1'b0;
            // A detection in the read-clear cycle is kept
            if (spc_hit) spc_q <= 1'b1;
            else if (rd_sts) spc_q <= 1'b0;
            trg_q    <= efr_q[`UEFC_EFR_RTS_BIT] && at_trig;
            seq_q    <= seq_d;
            resume_q <= hit_res | seq_res;
            pause_q  <= hit_pau | seq_pau;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            hrdata_out      <= 32'h0000_0000;
            hreadyout_out   <= 1'b1;
            hresp_out       <= 1'b0;
            divisor_out     <= 16'h0000;
            enh_bits_out    <= 9'h000;
            tx_halt_out     <= 1'b0;
            rts_out         <= 1'b0;
            rx_trig_irq_out <= 1'b0;
            sw_tx_mode_out  <= 2'b00;
            rx_resume_out   <= 1'b0;
            rx_pause_out    <= 1'b0;
        end else begin
            hrdata_out      <= rd_pend_q ? rd_word : rdata_q;
            hreadyout_out   <= ~(accept & ~hwrite_in);
            hresp_out       <= 1'b0;
            divisor_out     <= {div_hi_q, div_lo_q};
            enh_bits_out    <= efr_q[`UEFC_EFR_ENH_BIT] ? enh_q : 9'h000;
            tx_halt_out     <= efr_q[`UEFC_EFR_CTS_BIT] & cts_q;
            rts_out         <= efr_q[`UEFC_EFR_RTS_BIT] ? rts_auto_q : sw_rts_q;
            rx_trig_irq_out <= efr_q[`UEFC_EFR_RTS_BIT] && at_trig;
            sw_tx_mode_out  <= tx_mode;
            rx_resume_out   <= resume_q;
            rx_pause_out    <= pause_q;
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    property p_cnt_hidden;
        rd_pend_q && req_q.addr == `UEFC_OFS_TX_SPACE && !cnt_ok |=> hrdata_out == 32'h0000_0000;
    endproperty
    a_cnt_hidden: assert property (p_cnt_hidden) else $error("counter readable while disabled");

    property p_cnt_shown;
        rd_pend_q && req_q.addr == `UEFC_OFS_RX_FILL && cnt_ok |=> hrdata_out[7:0] == $past(rx_fill_in);
    endproperty
    a_cnt_shown: assert property (p_cnt_shown) else $error("fill count not returned");

    property p_rsvd_bank;
        wr_sel && new_bank == 2'b11 |=> $stable(bank_q);
    endproperty
    a_rsvd_bank: assert property (p_rsvd_bank) else $error("reserved bank changed visibility");

    property p_cts_halt;
        cts_in ##2 efr_q[`UEFC_EFR_CTS_BIT] |=> tx_halt_out;
    endproperty
    a_cts_halt: assert property (p_cts_halt) else $error("transmit not halted by CTS");

    property p_rts_sw;
        !efr_q[6] |=> rts_out == $past(sw_rts_q);
    endproperty
    a_rts_sw: assert property (p_rts_sw) else $error("RTS not software driven");

    property p_enh_gate;
        wr_enh && !efr_q[4] |=> $stable(enh_q);
    endproperty
    a_enh_gate: assert property (p_enh_gate) else $error("enhanced bits changed while gated");

    property p_spc_set;
        spc_hit |=> spc_q ##1 (spc_q || $past(rd_pend_q));
    endproperty
    a_spc_set: assert property (p_spc_set) else $error("special character not flagged");

    property p_divisor;
        wr_dhi |=> ##1 divisor_out[15:8] == $past(hwdata_in[7:0], 2);
    endproperty
    a_divisor: assert property (p_divisor) else $error("divisor high byte wrong");

    property p_read_wait;
        accept && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

    property p_msr_read;
        rd_pend_q && req_q.addr == `UEFC_OFS_SELECT |=> hrdata_out[7:0] == $past(modem_status_in);
    endproperty
    a_msr_read: assert property (p_msr_read) else $error("select address did not return modem status");

    property p_tx_shown;
        rd_pend_q && req_q.addr == `UEFC_OFS_TX_SPACE && cnt_ok |=> hrdata_out[7:0] == $past(tx_free_in);
    endproperty
    a_tx_shown: assert property (p_tx_shown) else $error("space count not returned");

    property p_wrong_bank;
        rd_pend_q && !rd_vis |=> hrdata_out == 32'h0000_0000;
    endproperty
    a_wrong_bank: assert property (p_wrong_bank) else $error("hidden register readable");

    property p_sel_write;
        wr_sel |=> cnt_en_q == $past(hwdata_in[`UEFC_SEL_CNT_BIT]);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("counter enable not taken");

    property p_irq_level;
        efr_q[`UEFC_EFR_RTS_BIT] && at_trig |=> rx_trig_irq_out;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("trigger interrupt missing");

    property p_rts_rise;
        rts_set |=> rts_auto_q;
    endproperty
    a_rts_rise: assert property (p_rts_rise) else $error("automatic RTS not raised");

    property p_rts_fall;
        rts_clr |=> !rts_auto_q;
    endproperty
    a_rts_fall: assert property (p_rts_fall) else $error("automatic RTS not lowered");

    property p_tx_mode;
        wr_efr |=> ##1 sw_tx_mode_out == $past(hwdata_in[3:2], 2);
    endproperty
    a_tx_mode: assert property (p_tx_mode) else $error("transmit flow mode wrong");

    property p_enh_out;
        !efr_q[`UEFC_EFR_ENH_BIT] |=> enh_bits_out == 9'h000;
    endproperty
    a_enh_out: assert property (p_enh_out) else $error("enhanced bits shown while gated");

    property p_dual_seq;
        seq_res |=> ##1 rx_resume_out;
    endproperty
    a_dual_seq: assert property (p_dual_seq) else $error("resume pair not flagged");

    property p_pause_pulse;
        hit_pau |=> ##1 rx_pause_out;
    endproperty
    a_pause_pulse: assert property (p_pause_pulse) else $error("pause character not flagged");
endmodule // uefc_top
`default_nettype wire

// [testbench/uefc_peer.sv]
// Behavioural modem peer on the line side of the extended-feature block
`timescale 1ns/10ps
`default_nettype none
module uefc_peer (
    input  wire logic       clk_sys_in,
    output logic            cts_out,
    output logic [7:0]      msr_out,
    output logic [7:0]      free_out,
    output logic [7:0]      fill_out,
    output logic            valid_out,
    output logic [7:0]      char_out
);
    initial begin
        cts_out = 1'b0;
        msr_out = 8'h00;
        free_out = 8'h00;
        fill_out = 8'h00;
        valid_out = 1'b0;
        char_out = 8'h00;
    end
    // Levels move just after an edge, like a peer seen through the same clock
    task automatic set(input logic c, input logic [7:0] m, input logic [7:0] f, input logic [7:0] r);
        @(posedge clk_sys_in);
        cts_out <= c;
        msr_out <= m;
        free_out <= f;
        fill_out <= r;
    endtask
    // Only control characters or bytes clear of them are sent
    task automatic send(input logic [7:0] c);
        @(posedge clk_sys_in);
        valid_out <= 1'b1;
        char_out <= c;
        @(posedge clk_sys_in);
        valid_out <= 1'b0;
        // Inverse of the last byte, so a stale character never looks held
        char_out <= ~c;
    endtask
endmodule // uefc_peer
`default_nettype wire

// [testbench/tb_top.sv]
// Register-level testbench of the extended-feature block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clk_sys_in;
    logic        rst_in;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic        cts;
    logic        rx_valid;
    logic [7:0]  modem_status_reg;
    logic [7:0]  free;
    logic [7:0]  fill;
    logic [7:0]  rx_char;
    logic [15:0] divisor;
    logic [8:0]  enh;
    logic        halt;
    logic        rts;
    logic        irq;
    logic [1:0]  mode;
    logic        res_p;
    logic        pau_p;
    logic [31:0] rd;
    int          errors;
    int          tests_run;
    int          n_res;
    int          n_pau;
    uefc_top uefc_top_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp), .cts_in(cts), .modem_status_in(modem_status_reg), .tx_free_in(free),
        .rx_fill_in(fill), .rx_char_valid_in(rx_valid), .rx_char_in(rx_char), .divisor_out(divisor),
        .enh_bits_out(enh), .tx_halt_out(halt), .rts_out(rts), .rx_trig_irq_out(irq),
        .sw_tx_mode_out(mode), .rx_resume_out(res_p), .rx_pause_out(pau_p));
    uefc_peer peer_i (.clk_sys_in(clk_sys_in), .cts_out(cts), .msr_out(modem_status_reg), .free_out(free),
        .fill_out(fill), .valid_out(rx_valid), .char_out(rx_char));
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) begin
        if (res_p === 1'b1) n_res++;
        if (pau_p === 1'b1) n_pau++;
    end
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: pin %h expected %h", $time, got, exp);
        end
    endtask
    // Ready is stable between edges, so it is looked at on the falling edge
    task automatic wait_rdy;
        do @(negedge clk_sys_in); while (hready !== 1'b1);
        @(posedge clk_sys_in);
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        chk_rd(rd, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    task automatic done(input string name);
        $display("test %s finished, mismatches so far %0d", name, errors);
    endtask
    task automatic match(input logic [3:0] s, input logic [7:0] a, input logic [7:0] b,
                         input logic [1:0] er, input logic [1:0] ep);
        wr(8'h18, {28'h0000000, s});
        n_res = 0;
        n_pau = 0;
        peer_i.send(a);
        peer_i.send(b);
        idle(4);
        chk_pin(16'(n_res), {14'h0000, er});
        chk_pin(16'(n_pau), {14'h0000, ep});
    endtask
    initial begin
        #200000;
        errors++;
        wrap_up();
    end
    initial begin
        rst_in = 1'b1;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h00000000;
        errors = 0;
        tests_run = 0;
        repeat (8) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        peer_i.set(1'b0, 8'hA5, 8'h20, 8'h07);
        rdc(8'h00, 32'h000000A5);
        chk_pin({15'h0000, hresp}, 16'h0000);
        wr(8'h04, 32'h0000005A);
        rdc(8'h04, 32'h0000005A);
        wr(8'h04, 32'hFFFFFFFF);
        rdc(8'h04, 32'h000000FF);
        done("select_scratch");
        rdc(8'h10, 32'h00000000);
        wr(8'h00, 32'h00000001);
        rdc(8'h10, 32'h00000020);
        rdc(8'h14, 32'h00000007);
        wr(8'h00, 32'h00000003);
        rdc(8'h10, 32'h00000000);
        wr(8'h00, 32'h000000F9);
        rdc(8'h14, 32'h00000007);
        wr(8'h00, 32'h00000007);
        rdc(8'h04, 32'h000000FF);
        wr(8'h10, 32'h00000055);
        rdc(8'h10, 32'h00000020);
        done("level_counters");
        wr(8'h00, 32'h00000002);
        wr(8'h08, 32'h00000034);
        wr(8'h0C, 32'h00000012);
        idle(2);
        chk_pin(divisor, 16'h1234);
        rdc(8'h0C, 32'h00000012);
        rdc(8'h04, 32'h00000000);
        wr(8'h00, 32'h00000000);
        rdc(8'h08, 32'h00000000);
        done("divisor_banks");
        wr(8'h1C, 32'h00010000);
        idle(3);
        chk_pin({15'h0000, rts}, 16'h0001);
        wr(8'h1C, 32'h00000000);
        idle(3);
        chk_pin({15'h0000, rts}, 16'h0000);
        wr(8'h00, 32'h00000004);
        wr(8'h18, 32'h00000010);
        wr(8'h00, 32'h00000000);
        wr(8'h1C, 32'h00000735);
        idle(2);
        chk_pin({7'h00, enh}, 16'h01F5);
        wr(8'h00, 32'h00000004);
        wr(8'h18, 32'h00000000);
        wr(8'h00, 32'h00000000);
        wr(8'h1C, 32'h00000000);
        idle(2);
        chk_pin({7'h00, enh}, 16'h0000);
        wr(8'h00, 32'h00000004);
        wr(8'h18, 32'h00000010);
        idle(2);
        chk_pin({7'h00, enh}, 16'h01F5);
        done("enhanced_gate");
        peer_i.set(1'b1, 8'hA5, 8'h20, 8'h00);
        wr(8'h18, 32'h00000000);
        idle(6);
        chk_pin({15'h0000, halt}, 16'h0000);
        wr(8'h18, 32'h00000080);
        idle(6);
        chk_pin({15'h0000, halt}, 16'h0001);
        peer_i.set(1'b0, 8'hA5, 8'h20, 8'h00);
        idle(6);
        chk_pin({15'h0000, halt}, 16'h0000);
        done("auto_cts");
        wr(8'h00, 32'h00000002);
        wr(8'h28, 32'h00000004);
        wr(8'h00, 32'h00000004);
        wr(8'h18, 32'h00000040);
        peer_i.set(1'b0, 8'hA5, 8'h20, 8'h05);
        idle(4);
        chk_pin({14'h0000, rts, irq}, 16'h0003);
        peer_i.set(1'b0, 8'hA5, 8'h20, 8'h03);
        idle(4);
        chk_pin({14'h0000, rts, irq}, 16'h0002);
        peer_i.set(1'b0, 8'hA5, 8'h20, 8'h02);
        idle(4);
        chk_pin({14'h0000, rts, irq}, 16'h0000);
        peer_i.set(1'b0, 8'hA5, 8'h20, 8'h04);
        idle(4);
        chk_pin({14'h0000, rts, irq}, 16'h0001);
        rdc(8'h24, 32'h00000001);
        done("auto_rts");
        for (int m = 0; m < 4; m++) begin
            wr(8'h18, {28'h0000000, 2'(m), 2'h0});
            idle(2);
            chk_pin({14'h0000, mode}, 16'(m));
        end
        wr(8'h20, 32'h14131211);
        match(4'h2, 8'h11, 8'h13, 2'h1, 2'h1);
        match(4'h2, 8'h10, 8'h12, 2'h0, 2'h0);
        match(4'h1, 8'h12, 8'h14, 2'h1, 2'h1);
        match(4'hB, 8'h11, 8'h14, 2'h1, 2'h1);
        match(4'hF, 8'h11, 8'h12, 2'h1, 2'h0);
        match(4'hF, 8'h12, 8'h11, 2'h0, 2'h0);
        match(4'hF, 8'h13, 8'h14, 2'h0, 2'h1);
        match(4'h0, 8'h11, 8'h13, 2'h0, 2'h0);
        done("char_match");
        wr(8'h18, 32'h00000020);
        peer_i.send(8'h13);
        idle(3);
        rdc(8'h24, 32'h00000000);
        peer_i.send(8'h14);
        idle(3);
        rdc(8'h24, 32'h00000010);
        rdc(8'h24, 32'h00000000);
        done("special_char");
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
